// ==== msd_pkg.sv ====
package msd_pkg;

    // ****************************************************************
    // Register map and field positions
    // ****************************************************************
    localparam logic [7:0] PAGE_OFFSET      = 8'hE0;
    localparam logic [7:0] SPACE_MAP_OFFSET = 8'hE2;
    localparam logic [7:0] SPACE_MAP_MASK   = 8'h9F;
    localparam logic [7:0] PAGE_RESET       = 8'h00;
    localparam logic [7:0] SPACE_MAP_RESET  = 8'h0C;

    localparam int SM_SRAM_CODE  = 0;
    localparam int SM_EEPROM_IN_CODE_SPACE    = 1;
    localparam int SM_FLASH_IN_CODE_SPACE    = 2;
    localparam int SM_EEPROM_IN_DATA_SPACE    = 3;
    localparam int SM_FLASH_IN_DATA_SPACE    = 4;
    localparam int SM_PERIPHERAL_IO_ENABLE     = 7;

    localparam int IN_BUS_WIDTH  = 73;

    // ****************************************************************
    // Resolved target of a bus cycle
    // ****************************************************************
    typedef enum logic [2:0] {
        MSD_TGT_NONE,
        MSD_TGT_SRAM,
        MSD_TGT_IO,
        MSD_TGT_PIO,
        MSD_TGT_EEPROM,
        MSD_TGT_FLASH
    } msd_target_t;

endpackage : msd_pkg

// ==== msd_memory_select.sv ====
`timescale 1ns/1ps

module msd_memory_select #(
    parameter int FLASH_SECTORS  = 8,
    parameter int EEPROM_SECTORS = 4
) (
    // Clock and reset
    input  wire logic                      mclk_i,
    input  wire logic                      rstn_i,
    // Microcontroller bus, synchronous to mclk_i
    input  wire logic [19:0]               addr_i,
    input  wire logic                      ext_addr_mode_i,
    input  wire logic                      code_fetch_strobe_i,
    input  wire logic                      read_strobe_i,
    input  wire logic                      write_strobe_i,
    input  wire logic                      cfg_space_sel_i,
    input  wire logic [7:0]                wdata_i,
    output logic      [7:0]                rdata_o,
    output logic                           rdata_oe_o,
    // Decode array raw selects
    input  wire logic [FLASH_SECTORS-1:0]  flash_sector_select_i,
    input  wire logic [EEPROM_SECTORS-1:0] eeprom_sector_select_i,
    input  wire logic [1:0]                sram_terms_i,
    input  wire logic                      io_select_i,
    input  wire logic                      pio_select_i,
    // Other logic array inputs
    input  wire logic [2:0]                bus_control_inputs_i,
    input  wire logic                      power_down_input_i,
    input  wire logic [23:0]               input_cells_i,
    input  wire logic [2:0]                port_d_i,
    input  wire logic [7:0]                output_cell_group1_feedback_i,
    input  wire logic [7:0]                output_cell_group2_feedback_i,
    input  wire logic                      eeprom_busy_i,
    // Resolved enables
    output logic [FLASH_SECTORS-1:0]       flash_enable_o,
    output logic [EEPROM_SECTORS-1:0]      eeprom_enable_o,
    output logic                           sram_enable_o,
    output logic                           io_enable_o,
    output logic                           peripheral_io_enable_o,
    output logic [2:0]                     target_o,
    // Logic array input bus and page bits
    output logic [msd_pkg::IN_BUS_WIDTH-1:0] array_in_bus_o,
    output logic [7:0]                     page_bits_o
);

    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [7:0] page_reg;
    logic [7:0] page_next;
    logic [7:0] space_map_reg;
    logic [7:0] space_map_next;

    wire        page_hit = cfg_space_sel_i
                           && addr_i[7:0] == msd_pkg::PAGE_OFFSET;
    wire        map_hit  = cfg_space_sel_i
                           && addr_i[7:0] == msd_pkg::SPACE_MAP_OFFSET;

    assign page_next      = (page_hit && write_strobe_i) ? wdata_i
                                                         : page_reg;
    assign space_map_next = (map_hit && write_strobe_i)
                            ? (wdata_i & msd_pkg::SPACE_MAP_MASK)
                            : space_map_reg;

    // Map comes up configured so decode works with no loading step
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            page_reg      <= msd_pkg::PAGE_RESET;
            space_map_reg <= msd_pkg::SPACE_MAP_RESET;
        end else begin
            page_reg      <= page_next;
            space_map_reg <= space_map_next;
        end
    end

    // ****************************************************************
    // Priority resolution and strobe gating
    // ****************************************************************
    // The new map is applied combinationally to the current cycle's
    // write value, so a rewrite takes effect in the same cycle as the write.
    wire [7:0] map_w = space_map_next;

    wire sram_sel  = |sram_terms_i;
    wire lvl1      = sram_sel | io_select_i
                     | (pio_select_i & map_w[msd_pkg::SM_PERIPHERAL_IO_ENABLE]);
    wire ee_any    = |eeprom_sector_select_i;
    wire fl_any    = |flash_sector_select_i;

    wire sram_ok   = read_strobe_i
                     | (code_fetch_strobe_i & map_w[msd_pkg::SM_SRAM_CODE]);
    wire ee_ok     = (read_strobe_i & map_w[msd_pkg::SM_EEPROM_IN_DATA_SPACE])
                     | (code_fetch_strobe_i
                        & map_w[msd_pkg::SM_EEPROM_IN_CODE_SPACE]);
    wire fl_ok     = (read_strobe_i & map_w[msd_pkg::SM_FLASH_IN_DATA_SPACE])
                     | (code_fetch_strobe_i
                        & map_w[msd_pkg::SM_FLASH_IN_CODE_SPACE]);

    // Level 1 blocks 2 and 3, level 2 blocks 3
    wire sram_go   = sram_sel & sram_ok;
    wire io_go     = ~sram_sel & io_select_i & read_strobe_i;
    wire pio_go    = ~sram_sel & ~io_select_i & pio_select_i
                     & map_w[msd_pkg::SM_PERIPHERAL_IO_ENABLE] & read_strobe_i;
    wire ee_go     = ~lvl1 & ee_any & ee_ok;
    wire fl_go     = ~lvl1 & ~ee_any & fl_any & fl_ok;

    wire [2:0] tgt_w = sram_go ? 3'(msd_pkg::MSD_TGT_SRAM)
                     : io_go   ? 3'(msd_pkg::MSD_TGT_IO)
                     : pio_go  ? 3'(msd_pkg::MSD_TGT_PIO)
                     : ee_go   ? 3'(msd_pkg::MSD_TGT_EEPROM)
                     : fl_go   ? 3'(msd_pkg::MSD_TGT_FLASH)
                     :           3'(msd_pkg::MSD_TGT_NONE);

    // ****************************************************************
    // Logic array input bus
    // ****************************************************************
    wire [15:0] dec_addr = ext_addr_mode_i ? addr_i[19:4]
                                           : addr_i[15:0];
    wire [msd_pkg::IN_BUS_WIDTH-1:0] in_bus_w = {
        eeprom_busy_i,
        output_cell_group2_feedback_i,
        output_cell_group1_feedback_i,
        page_reg,
        port_d_i,
        input_cells_i,
        power_down_input_i,
        ~rstn_i,
        bus_control_inputs_i,
        dec_addr
    };

    wire cfg_read = cfg_space_sel_i & read_strobe_i & (page_hit | map_hit);
    wire [7:0] rdata_w = page_hit ? page_reg
                       : map_hit  ? space_map_reg : 8'h00;

    // ****************************************************************
    // Registered outputs
    // ****************************************************************
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            flash_enable_o         <= '0;
            eeprom_enable_o        <= '0;
            sram_enable_o          <= 1'b0;
            io_enable_o            <= 1'b0;
            peripheral_io_enable_o <= 1'b0;
            target_o               <= 3'h0;
            array_in_bus_o         <= '0;
            page_bits_o            <= 8'h00;
            rdata_o                <= 8'h00;
            rdata_oe_o             <= 1'b0;
        end else begin
            flash_enable_o  <= fl_go ? flash_sector_select_i : '0;
            eeprom_enable_o <= ee_go ? eeprom_sector_select_i : '0;
            sram_enable_o          <= sram_go;
            io_enable_o            <= io_go;
            peripheral_io_enable_o <= pio_go;
            target_o               <= tgt_w;
            array_in_bus_o         <= in_bus_w;
            page_bits_o            <= page_reg;
            rdata_o                <= rdata_w;
            rdata_oe_o             <= cfg_read;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_ee_over_flash: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (ee_any && !lvl1 && ee_ok) |=> !(|flash_enable_o))
        else $error("flash enabled over eeprom");
    a_sram_wins: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (sram_sel && sram_ok) |=> sram_enable_o
            && !(|flash_enable_o) && !(|eeprom_enable_o))
        else $error("sram lost priority");
    a_one_level: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        $onehot0({sram_enable_o, io_enable_o, peripheral_io_enable_o,
                  |eeprom_enable_o, |flash_enable_o}))
        else $error("two targets enabled");
    a_code_gate: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (code_fetch_strobe_i && !read_strobe_i
         && !map_w[msd_pkg::SM_FLASH_IN_CODE_SPACE]) |=> !(|flash_enable_o))
        else $error("code fetch reached flash");
    a_read_gate: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (read_strobe_i && !code_fetch_strobe_i
         && !map_w[msd_pkg::SM_EEPROM_IN_DATA_SPACE]) |=> !(|eeprom_enable_o))
        else $error("read reached eeprom");
    a_map_write: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (map_hit && write_strobe_i) |=> space_map_reg
            == ($past(wdata_i) & msd_pkg::SPACE_MAP_MASK))
        else $error("map write lost");
    a_page_rw: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (page_hit && write_strobe_i) |=> ##1 page_bits_o == $past(wdata_i, 2)
            && array_in_bus_o[55:48] == $past(wdata_i, 2))
        else $error("page value not propagated");
    a_addr_sel: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        ext_addr_mode_i |=> array_in_bus_o[15:0]
            == $past(addr_i[19:4]))
        else $error("extended address not used");
    a_busy_bit: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        1'b1 |=> array_in_bus_o[72] == $past(eeprom_busy_i))
        else $error("busy flag missing");
    a_sram_only: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        !sram_sel |=> !sram_enable_o)
        else $error("sram enabled without select");

endmodule : msd_memory_select

// ==== msd_mcu_model.sv ====
`timescale 1ns/1ps

// ****************************************************************
// Microcontroller bus side facing the memory select block
// ****************************************************************
module msd_mcu_model (
    // Bus toward the device
    output logic [19:0] addr_o,
    output logic        ext_addr_mode_o,
    output logic        code_fetch_strobe_o,
    output logic        read_strobe_o,
    output logic        write_strobe_o,
    output logic        cfg_space_sel_o,
    output logic [7:0]  wdata_o
);
    initial begin
        {addr_o, ext_addr_mode_o, code_fetch_strobe_o, read_strobe_o,
         write_strobe_o, cfg_space_sel_o, wdata_o} = 33'h0_0000_0000;
    end

    // Called just after a rising edge; the cycle stands until the next call
    task automatic drive(input logic [19:0] a, input logic x, c, r, w, s,
                         input logic [7:0] d);
        addr_o              <= a;
        ext_addr_mode_o     <= x;
        code_fetch_strobe_o <= c;
        read_strobe_o       <= r;
        write_strobe_o      <= w;
        cfg_space_sel_o     <= s;
        // Released data lines flip, so a stale byte never looks valid
        wdata_o             <= w ? d : ~wdata_o;
    endtask : drive
endmodule : msd_mcu_model

// ==== msd_memory_select_tb.sv ====
`timescale 1ns/1ps

module msd_memory_select_tb;
    typedef struct {int due; int kind; logic [72:0] want;} msd_note_t;
    logic        mclk_i = 1'b0;
    logic        rstn_i = 1'b0;
    logic [19:0] addr;
    logic        ext, code, rd, wr, cfg, oe, sen, ioen, pen;
    logic [7:0]  wdata, rdata, pbits, fen, pg;
    logic [7:0]  fsel = 8'h00, fb1 = 8'h00, fb2 = 8'h00;
    logic [3:0]  esel = 4'h0, een;
    logic [1:0]  sram_t = 2'h0;
    logic [2:0]  ctl = 3'h0, pd = 3'h0, tgt;
    logic        io_s = 1'b0, pio_s = 1'b0, power_down_input = 1'b0, busy = 1'b0;
    logic [23:0] cells = 24'h00_0000;
    logic [72:0] abus;
    wire  [72:0] dec_seen = 73'({tgt, fen, een, sen, ioen, pen, oe});
    msd_note_t   notes[$];
    msd_note_t   cur;
    int          failures = 0, n_checks = 0, cyc = 0, seed = 69082;
    logic [7:0]  map_m = msd_pkg::SPACE_MAP_RESET, page_m = 8'h00;
    logic [7:0]  maps [8] = '{8'h0C, 8'h14, 8'h1F, 8'h00, 8'hFF, 8'h83,
                              8'h6B, 8'h9F};

    always #12.5 mclk_i = ~mclk_i;

    msd_mcu_model mcu (.addr_o(addr), .ext_addr_mode_o(ext),
        .code_fetch_strobe_o(code), .read_strobe_o(rd), .write_strobe_o(wr),
        .cfg_space_sel_o(cfg), .wdata_o(wdata));

    msd_memory_select dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .addr_i(addr),
        .ext_addr_mode_i(ext), .code_fetch_strobe_i(code),
        .read_strobe_i(rd), .write_strobe_i(wr), .cfg_space_sel_i(cfg),
        .wdata_i(wdata), .rdata_o(rdata), .rdata_oe_o(oe),
        .flash_sector_select_i(fsel), .eeprom_sector_select_i(esel),
        .sram_terms_i(sram_t), .io_select_i(io_s), .pio_select_i(pio_s),
        .bus_control_inputs_i(ctl), .power_down_input_i(power_down_input),
        .input_cells_i(cells), .port_d_i(pd),
        .output_cell_group1_feedback_i(fb1),
        .output_cell_group2_feedback_i(fb2), .eeprom_busy_i(busy),
        .flash_enable_o(fen), .eeprom_enable_o(een), .sram_enable_o(sen),
        .io_enable_o(ioen), .peripheral_io_enable_o(pen), .target_o(tgt),
        .array_in_bus_o(abus), .page_bits_o(pbits));

    // ************************************************************
    // Expected values and comparison
    // ************************************************************
    function automatic logic [18:0] dec_exp(input logic [7:0] m,
                                            input logic [15:0] sl,
                                            input logic c, r);
        msd_pkg::msd_target_t t;
        t = msd_pkg::MSD_TGT_NONE;
        // Priority is settled on selects first, then the strobe gate
        if (|sl[3:2]) begin
            if (r | c & m[0]) t = msd_pkg::MSD_TGT_SRAM;
        end else if (sl[1]) begin
            if (r) t = msd_pkg::MSD_TGT_IO;
        end else if (sl[0] & m[7]) begin
            if (r) t = msd_pkg::MSD_TGT_PIO;
        end else if (|sl[7:4]) begin
            if (r & m[3] | c & m[1]) t = msd_pkg::MSD_TGT_EEPROM;
        end else if (|sl[15:8]) begin
            if (r & m[4] | c & m[2]) t = msd_pkg::MSD_TGT_FLASH;
        end
        return {t, t == msd_pkg::MSD_TGT_FLASH ? sl[15:8] : 8'h00,
                t == msd_pkg::MSD_TGT_EEPROM ? sl[7:4] : 4'h0,
                t == msd_pkg::MSD_TGT_SRAM, t == msd_pkg::MSD_TGT_IO,
                t == msd_pkg::MSD_TGT_PIO, 1'b0};
    endfunction : dec_exp

    task automatic check(input logic [72:0] seen, want);
        n_checks++;
        if (seen !== want) begin
            failures++;
            $display("BAD %0t seen %h expected %h", $time, seen, want);
        end
    endtask : check

    task automatic note(input int k, input logic [72:0] want);
        notes.push_back('{cyc + 2, k, want});
    endtask : note

    // cv is {ext, code, rd, wr, cfg}; sl is {flash, eeprom, sram, io, pio}
    task automatic bus(input logic [19:0] a, input logic [4:0] cv,
                       input logic [7:0] d, input logic [15:0] sl);
        logic [47:0] r;
        logic        hit;
        r = 48'({$random(seed), $random(seed)});
        hit = cv[2] & cv[0] & (a[7:0] == msd_pkg::PAGE_OFFSET ||
                               a[7:0] == msd_pkg::SPACE_MAP_OFFSET);
        @(posedge mclk_i);
        mcu.drive(a, cv[4], cv[3], cv[2], cv[1], cv[0], d);
        {fsel, esel, sram_t, io_s, pio_s} <= sl;
        {busy, fb2, fb1, pd, cells, power_down_input, ctl} <= r;
        note(0, 73'(dec_exp(map_m, sl, cv[3], cv[2]) | 19'(hit)));
        note(1, {r[47:31], page_m, r[30:3], 1'b0, r[2:0],
                 cv[4] ? a[19:4] : a[15:0]});
        note(2, 73'(page_m));
        if (hit) note(3, 73'(a[1] ? map_m : page_m));
        if (cv[1] & cv[0] & a[7:0] == msd_pkg::PAGE_OFFSET) page_m = d;
        if (cv[1] & cv[0] & a[7:0] == msd_pkg::SPACE_MAP_OFFSET)
            map_m = d & msd_pkg::SPACE_MAP_MASK;
    endtask : bus

    task automatic rnd_cycle();
        logic [31:0] r;
        logic [31:0] a;
        r = $random(seed);
        a = $random(seed);
        // One select per priority level, so same-level spaces never collide
        bus(a[19:0], {r[12], r[11], ~r[11], 2'b00}, 8'h00,
            {r[3] ? 8'h01 << r[2:0] : 8'h00, r[6] ? 4'h1 << r[5:4] : 4'h0,
             r[8:7] == 2'd1 ? {r[10], ~r[10] | r[9]} : 2'b00,
             r[8:7] == 2'd2, r[8:7] == 2'd3});
    endtask : rnd_cycle

    task automatic summarize();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : summarize

    always @(posedge mclk_i) begin
        #1;
        cyc++;
        while (notes.size() > 0 && notes[0].due == cyc) begin
            cur = notes.pop_front();
            case (cur.kind)
                0: check(dec_seen, cur.want);
                1: check(abus, cur.want);
                2: check(73'(pbits), cur.want);
                default: check(73'(rdata), cur.want);
            endcase
        end
    end

    // ************************************************************
    // Stimulus
    // ************************************************************
    initial begin
        repeat (12) @(posedge mclk_i);
        rstn_i <= 1'b1;
        bus(20'h0_00E0, 5'b00101, 8'h00, 16'h0000);
        bus(20'h0_00E2, 5'b00101, 8'h00, 16'h0000);
        bus(20'h0_00E4, 5'b00101, 8'h00, 16'h0000);
        bus(20'h0_00E6, 5'b00011, 8'hA5, 16'h0000);
        for (int i = 0; i < 8; i++) begin
            bus(20'h0_00E2, 5'b00011, maps[i], 16'h0000);
            bus(20'h0_00E2, 5'b00101, 8'h00, 16'h0000);
            repeat (40) rnd_cycle();
            pg = 8'($random(seed));
            bus(20'h0_00E0, 5'b00011, pg, 16'h0000);
            bus(20'h0_00E0, 5'b00101, 8'h00, 16'h0000);
        end
        repeat (3) @(posedge mclk_i);
        summarize();
    end

    // The tests need about 400 cycles; this limit leaves a wide margin
    initial begin
        repeat (20000) @(posedge mclk_i);
        failures++;
        summarize();
    end
endmodule : msd_memory_select_tb
